// ---- pkg/dcm_pkg.sv ----
// Contract
// - Push mode: device starts each transmission on its own schedule; default.
// - Server-poll mode: send only on server request, never on schedule.
// - Either or both inputs activatable, both by default; inactive inputs ignored; code still shows an inactive pin at INPUT_STATE.
// - One shared sampling period 60..604800 s, default 86400, captures counters.
// - Transmission interval 60..604800 s; value 0, the default, disables it.
// - Interval at least twice sampling: send history; equal: latest sample only.
// - Both intervals used in whole minutes, remainder seconds dropped.
// - Each input detects low, high or both states; both by default.
// - Event counts only if state persists beyond debounce, 10 ms..10 min, 100 ms.
// - Optional per-input time counter, off by default, seconds in abnormal state.
// - Alarm when event count reaches threshold; 0 disables, default 1.
// - Alarm when one event outlasts duration threshold; 0 disables, default.
// - Monitoring keeps running whether or not the uplink is available.
// - Monitoring never pauses or loses events during a transmission.
// - Count every accepted change; send saved count with current input state; code counts detected changes only, sends the state taken with it.
// - With history, at most 48 samples per input in one message.
// - Counters volatile, cleared only by explicit command or reset.
// - Detection type code: 0 low, 1 high, 2 both.
package dcm_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 32'h0000_000A;
	localparam int MS_NS         = 32'h000F_4240;
	localparam int CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_PER_S      = 32'h0000_03E8;
	localparam int S_PER_MIN     = 32'h0000_003C;
	// ----------------------------------------
	// Widths and limits
	// ----------------------------------------
	localparam int NUM_IN        = 32'h0000_0002;
	localparam int CNT_W         = 32'h0000_0020;
	localparam int THR_W         = 32'h0000_001F;
	localparam int SEC_W         = 32'h0000_0014;
	localparam int MIN_W         = 32'h0000_000E;
	localparam int DEB_W         = 32'h0000_0014;
	localparam int PERIOD_MIN_S  = 32'h0000_003C;
	localparam int PERIOD_MAX_S  = 32'h0009_3A80;
	localparam int SAMPLE_DEF_S  = 32'h0001_5180;
	localparam int TX_DEF_S      = 32'h0000_0000;
	localparam int DEB_MIN_MS    = 32'h0000_000A;
	localparam int DEB_MAX_MS    = 32'h0009_27C0;
	localparam int DEB_DEF_MS    = 32'h0000_0064;
	localparam int COS_DEF       = 32'h0000_0001;
	localparam int DUR_DEF       = 32'h0000_0000;
	localparam int HIST_RATIO    = 32'h0000_0002;
	localparam int MAX_HIST      = 32'h0000_0030;
	localparam int FIFO_DEPTH    = 32'h0000_0010;
	// ----------------------------------------
	// Sample word: per input {en, state, events, seconds}
	// ----------------------------------------
	localparam int SLICE_W       = 2 * CNT_W + 2;
	localparam int WORD_W        = NUM_IN * SLICE_W;
	localparam int TM_LSB        = 32'h0000_0000;
	localparam int EV_LSB        = CNT_W;
	localparam int ST_BIT        = 2 * CNT_W;
	localparam int EN_BIT        = 2 * CNT_W + 1;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		DET_LOW  = 2'b00,
		DET_HIGH = 2'b01,
		DET_BOTH = 2'b10
	} dcm_det_e;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_DROP = 2'b01,
		TX_SEND = 2'b10
	} dcm_tx_e;
endpackage : dcm_pkg

// ---- design/dcm_fifo.sv ----
`timescale 1ns/1ps
module dcm_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Fill side
	input  wire logic                 in_valid,
	output logic                      in_ready,
	input  wire logic [W-1:0]         in_data,
	// Drain side
	output logic                      out_valid,
	input  wire logic                 out_ready,
	output logic [W-1:0]              out_data,
	output logic [$clog2(D):0]        level
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem_ff [D];
	logic [AW:0]   wr_ff;
	logic [AW:0]   rd_ff;
	wire           do_wr = in_valid & in_ready;
	wire           do_rd = out_valid & out_ready;

	assign level     = wr_ff - rd_ff;
	assign in_ready  = (level != (AW+1)'(D));
	assign out_valid = (level != '0);
	assign out_data  = mem_ff[rd_ff[AW-1:0]];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			wr_ff <= wr_ff + (AW+1)'(do_wr);
			rd_ff <= rd_ff + (AW+1)'(do_rd);
		end
	end

	// Storage has no reset: contents are qualified by the pointers
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
		end
	end
endmodule : dcm_fifo

// ---- design/dcm_monitor.sv ----
`timescale 1ns/1ps
module dcm_monitor #(
	parameter int P_CYC_PER_MS = dcm_pkg::CYC_PER_MS,
	parameter int P_MS_PER_S   = dcm_pkg::MS_PER_S,
	parameter int P_S_PER_MIN  = dcm_pkg::S_PER_MIN,
	parameter int P_FIFO_DEPTH = dcm_pkg::FIFO_DEPTH,
	parameter int P_MAX_HIST   = dcm_pkg::MAX_HIST
) (
	// Clock and reset
	input  wire logic                                          CLK_SYS,
	input  wire logic                                          RST,
	// Contact pins
	input  wire logic                                          CONTACT_INPUT_FIRST,
	input  wire logic                                          CONTACT_INPUT_SECOND,
	// Global configuration
	input  wire logic                                          SERVER_POLL_MODE,
	input  wire logic [dcm_pkg::NUM_IN-1:0]                    INPUT_ENABLE,
	input  wire logic [dcm_pkg::SEC_W-1:0]                     SAMPLE_PERIOD_S,
	input  wire logic [dcm_pkg::SEC_W-1:0]                     TX_INTERVAL_S,
	// Per-input configuration, index 0 is the first input
	input  wire logic [dcm_pkg::NUM_IN-1:0][1:0]               DETECT_TYPE,
	input  wire logic [dcm_pkg::NUM_IN-1:0][dcm_pkg::DEB_W-1:0] DEBOUNCE_MS,
	input  wire logic [dcm_pkg::NUM_IN-1:0]                    TIME_CNT_EN,
	input  wire logic [dcm_pkg::NUM_IN-1:0][dcm_pkg::THR_W-1:0] COS_THRESHOLD,
	input  wire logic [dcm_pkg::NUM_IN-1:0][dcm_pkg::THR_W-1:0] DUR_THRESHOLD_S,
	// Commands, one-cycle pulses
	input  wire logic [dcm_pkg::NUM_IN-1:0]                    EVT_CNT_CLR,
	input  wire logic [dcm_pkg::NUM_IN-1:0]                    TIME_CNT_CLR,
	input  wire logic                                          SERVER_READ_REQ,
	// Status
	output logic [dcm_pkg::NUM_IN-1:0]                         INPUT_STATE,
	output logic [dcm_pkg::NUM_IN-1:0]                         COS_ALARM_FLAG,
	output logic [dcm_pkg::NUM_IN-1:0]                         DUR_ALARM_FLAG,
	output logic [dcm_pkg::NUM_IN-1:0]                         COS_ALARM_PULSE,
	output logic [dcm_pkg::NUM_IN-1:0]                         DUR_ALARM_PULSE,
	// Message stream toward the uplink
	output logic                                               MSG_VALID,
	input  wire logic                                          MSG_READY,
	output logic [dcm_pkg::WORD_W-1:0]                         MSG_DATA,
	output logic                                               MSG_LAST
);
	localparam int NI = dcm_pkg::NUM_IN;
	localparam int CW = dcm_pkg::CNT_W;
	localparam int MW = dcm_pkg::MIN_W;
	localparam int LW = $clog2(P_FIFO_DEPTH) + 1;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NI-1:0] sync1_ff;
	logic [NI-1:0] sync2_ff;
	logic [2:0]    seed_ff;
	// Seeding lasts until the second stage carries the pin: no false edge
	wire           seeded = seed_ff[2];

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sync1_ff  <= '0;
			sync2_ff  <= '0;
			seed_ff   <= '0;
		end else begin
			sync1_ff  <= {CONTACT_INPUT_SECOND, CONTACT_INPUT_FIRST};
			sync2_ff  <= sync1_ff;
			seed_ff   <= {seed_ff[1:0], 1'b1};
		end
	end

	// ----------------------------------------
	// Timebase: ms, second and minute ticks
	// ----------------------------------------
	logic [31:0] cyc_cnt_ff;
	logic [15:0] ms_cnt_ff;
	logic [7:0]  sec_cnt_ff;
	logic        ms_tick_ff;
	logic        sec_tick_ff;
	logic        min_tick_ff;
	wire         cyc_wrap = (cyc_cnt_ff == 32'(P_CYC_PER_MS - 1));
	wire         ms_wrap  = cyc_wrap & (ms_cnt_ff == 16'(P_MS_PER_S - 1));
	wire         sec_wrap = ms_wrap & (sec_cnt_ff == 8'(P_S_PER_MIN - 1));

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cyc_cnt_ff  <= '0;
			ms_cnt_ff   <= '0;
			sec_cnt_ff  <= '0;
			ms_tick_ff  <= 1'b0;
			sec_tick_ff <= 1'b0;
			min_tick_ff <= 1'b0;
		end else begin
			cyc_cnt_ff  <= cyc_wrap ? '0 : cyc_cnt_ff + 32'h0000_0001;
			ms_cnt_ff   <= ms_wrap ? '0 : ms_cnt_ff + 16'(cyc_wrap);
			sec_cnt_ff  <= sec_wrap ? '0 : sec_cnt_ff + 8'(ms_wrap);
			ms_tick_ff  <= cyc_wrap;
			sec_tick_ff <= ms_wrap;
			min_tick_ff <= sec_wrap;
		end
	end

	// ----------------------------------------
	// Per-input monitor
	// ----------------------------------------
	logic [NI-1:0][CW-1:0] ev_cnt;
	logic [NI-1:0][CW-1:0] tm_cnt;
	logic [NI-1:0]         stable;
	logic [NI-1:0]         cos_flag;
	logic [NI-1:0]         dur_flag;
	logic [NI-1:0]         cos_hit;
	logic [NI-1:0]         dur_hit;

	for (genvar i = 0; i < NI; i++) begin : g_in
		logic [dcm_pkg::DEB_W-1:0] deb_cnt_ff;
		logic                      stable_ff;
		logic                      in_event_ff;
		logic [CW-1:0]             ev_ff;
		logic [CW-1:0]             tm_ff;
		logic [CW-1:0]             dur_ff;
		logic                      cos_flag_ff;
		logic                      dur_flag_ff;

		// Out-of-range debounce settings are pulled to the nearest limit
		wire [dcm_pkg::DEB_W-1:0] deb_lim =
			(DEBOUNCE_MS[i] < dcm_pkg::DEB_W'(dcm_pkg::DEB_MIN_MS)) ?
				dcm_pkg::DEB_W'(dcm_pkg::DEB_MIN_MS) :
			(DEBOUNCE_MS[i] > dcm_pkg::DEB_W'(dcm_pkg::DEB_MAX_MS)) ?
				dcm_pkg::DEB_W'(dcm_pkg::DEB_MAX_MS) : DEBOUNCE_MS[i];
		wire raw      = sync2_ff[i];
		wire en       = INPUT_ENABLE[i];
		wire diff     = raw ^ stable_ff;
		wire accept   = en & diff & ms_tick_ff & (deb_cnt_ff == deb_lim);
		// Code 3 is undefined and detects nothing
		wire hit      = (DETECT_TYPE[i] == dcm_pkg::DET_BOTH) |
		                ((DETECT_TYPE[i] == dcm_pkg::DET_HIGH) & raw) |
		                ((DETECT_TYPE[i] == dcm_pkg::DET_LOW) & ~raw);
		wire evt      = accept & hit;
		wire leave    = accept & ~hit;
		wire sec_in   = sec_tick_ff & in_event_ff;
		wire [CW-1:0] nxt_deb_ev = evt ? ev_ff + 32'h0000_0001 : ev_ff;
		wire [CW-1:0] nxt_ev = EVT_CNT_CLR[i] ? CW'(evt) : nxt_deb_ev;
		wire tm_inc   = sec_in & TIME_CNT_EN[i];
		wire [CW-1:0] nxt_tm = TIME_CNT_CLR[i] ? CW'(tm_inc) :
		                       tm_ff + CW'(tm_inc);
		wire [CW-1:0] nxt_dur = evt ? '0 : dur_ff + CW'(sec_in);
		wire [CW-1:0] cos_thr = {1'b0, COS_THRESHOLD[i]};
		wire [CW-1:0] dur_thr = {1'b0, DUR_THRESHOLD_S[i]};

		assign cos_hit[i] = evt & (cos_thr != '0) & (nxt_ev == cos_thr);
		// Alarm at the tick that takes the event past the threshold
		assign dur_hit[i] = sec_in & (dur_thr != '0) & (dur_ff == dur_thr);

		always_ff @(posedge CLK_SYS or posedge RST) begin
			if (RST) begin
				deb_cnt_ff  <= '0;
				stable_ff   <= 1'b0;
				in_event_ff <= 1'b0;
				ev_ff       <= '0;
				tm_ff       <= '0;
				dur_ff      <= '0;
				cos_flag_ff <= 1'b0;
				dur_flag_ff <= 1'b0;
			end else begin
				deb_cnt_ff  <= (~seeded | ~en | ~diff | accept) ? '0 :
				               deb_cnt_ff + dcm_pkg::DEB_W'(ms_tick_ff);
				// Idle level taken after reset so the first state is no event
				stable_ff   <= (~seeded | ~en | accept) ? raw : stable_ff;
				in_event_ff <= en & (evt | (in_event_ff & ~leave));
				ev_ff       <= nxt_ev;
				tm_ff       <= nxt_tm;
				dur_ff      <= nxt_dur;
				// Set wins over the clear
				cos_flag_ff <= cos_hit[i] | (cos_flag_ff & ~EVT_CNT_CLR[i]);
				dur_flag_ff <= dur_hit[i] | (dur_flag_ff & ~evt);
			end
		end

		assign ev_cnt[i]   = ev_ff;
		assign tm_cnt[i]   = tm_ff;
		assign stable[i]   = stable_ff;
		assign cos_flag[i] = cos_flag_ff;
		assign dur_flag[i] = dur_flag_ff;
	end

	// ----------------------------------------
	// Live sample word
	// ----------------------------------------
	logic [dcm_pkg::WORD_W-1:0] live_word;

	always_comb begin
		live_word = '0;
		for (int k = 0; k < NI; k++) begin
			if (INPUT_ENABLE[k]) begin
				live_word[k*dcm_pkg::SLICE_W + dcm_pkg::TM_LSB +: CW] = tm_cnt[k];
				live_word[k*dcm_pkg::SLICE_W + dcm_pkg::EV_LSB +: CW] = ev_cnt[k];
				live_word[k*dcm_pkg::SLICE_W + dcm_pkg::ST_BIT]      = stable[k];
				live_word[k*dcm_pkg::SLICE_W + dcm_pkg::EN_BIT]      = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Sampling and transmission schedulers
	// ----------------------------------------
	wire [dcm_pkg::SEC_W-1:0] samp_s =
		(SAMPLE_PERIOD_S < dcm_pkg::SEC_W'(dcm_pkg::PERIOD_MIN_S)) ?
			dcm_pkg::SEC_W'(dcm_pkg::PERIOD_MIN_S) :
		(SAMPLE_PERIOD_S > dcm_pkg::SEC_W'(dcm_pkg::PERIOD_MAX_S)) ?
			dcm_pkg::SEC_W'(dcm_pkg::PERIOD_MAX_S) : SAMPLE_PERIOD_S;
	wire [dcm_pkg::SEC_W-1:0] tx_s =
		(TX_INTERVAL_S > dcm_pkg::SEC_W'(dcm_pkg::PERIOD_MAX_S)) ?
			dcm_pkg::SEC_W'(dcm_pkg::PERIOD_MAX_S) : TX_INTERVAL_S;
	// Remainder seconds discarded by the integer division
	wire [MW-1:0] samp_min = MW'(samp_s / dcm_pkg::SEC_W'(dcm_pkg::S_PER_MIN));
	wire [MW-1:0] tx_min   = MW'(tx_s / dcm_pkg::SEC_W'(dcm_pkg::S_PER_MIN));
	wire          tx_off   = (tx_min == '0);
	wire          history  = ({2'b00, tx_min} >=
	                          (MW+2)'(samp_min) * (MW+2)'(dcm_pkg::HIST_RATIO));

	logic [MW-1:0]              samp_cnt_ff;
	logic [MW-1:0]              tx_cnt_ff;
	logic                       snap_vld_ff;
	logic [dcm_pkg::WORD_W-1:0] snap_ff;
	logic                       req_pend_ff;
	wire                        fifo_in_ready;
	wire                        samp_due = min_tick_ff & (samp_cnt_ff + MW'(1'b1) >= samp_min);
	wire                        tx_run   = ~SERVER_POLL_MODE & ~tx_off;
	wire                        tx_due   = tx_run & min_tick_ff &
	                                       (tx_cnt_ff + MW'(1'b1) >= tx_min);
	wire                        msg_req  = tx_due |
	                                       (SERVER_POLL_MODE & SERVER_READ_REQ);
	wire                        take_req;

	// A full buffer holds the snapshot back; the newest sample replaces it
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			samp_cnt_ff <= '0;
			tx_cnt_ff   <= '0;
			snap_vld_ff <= 1'b0;
			snap_ff     <= '0;
			req_pend_ff <= 1'b0;
		end else begin
			samp_cnt_ff <= samp_due ? '0 : samp_cnt_ff + MW'(min_tick_ff);
			tx_cnt_ff   <= (~tx_run | tx_due) ? '0 : tx_cnt_ff + MW'(min_tick_ff);
			snap_vld_ff <= samp_due | (snap_vld_ff & ~fifo_in_ready);
			snap_ff     <= samp_due ? live_word : snap_ff;
			req_pend_ff <= msg_req | (req_pend_ff & ~take_req);
		end
	end

	// ----------------------------------------
	// Sample buffer
	// ----------------------------------------
	wire                        fifo_out_valid;
	wire                        fifo_out_ready;
	wire [dcm_pkg::WORD_W-1:0]  fifo_out_data;
	wire [LW-1:0]               fifo_level;

	dcm_fifo #(
		.W (dcm_pkg::WORD_W),
		.D (P_FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst       (RST),
		.in_valid  (snap_vld_ff),
		.in_ready  (fifo_in_ready),
		.in_data   (snap_ff),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// ----------------------------------------
	// Message sequencer
	// ----------------------------------------
	dcm_pkg::dcm_tx_e           tx_st_ff;
	dcm_pkg::dcm_tx_e           nxt_tx_st;
	logic [7:0]                 sent_ff;
	logic                       out_vld_ff;
	logic                       out_last_ff;
	logic [dcm_pkg::WORD_W-1:0] out_data_ff;
	wire  can_load  = ~out_vld_ff | MSG_READY;
	wire  one_left  = (fifo_level == LW'(1));
	wire  cap_hit   = (sent_ff == 8'(P_MAX_HIST - 1));
	wire  live_send = (tx_st_ff == dcm_pkg::TX_IDLE) & req_pend_ff &
	                  ~fifo_out_valid & can_load;
	wire  pop_send  = (tx_st_ff == dcm_pkg::TX_SEND) & fifo_out_valid & can_load;
	wire  pop_drop  = (tx_st_ff == dcm_pkg::TX_DROP) & ~one_left;
	wire  send_last = one_left | cap_hit;

	assign take_req       = (tx_st_ff == dcm_pkg::TX_IDLE) & req_pend_ff &
	                        (fifo_out_valid | can_load);
	assign fifo_out_ready = pop_send | pop_drop;

	always_comb begin
		nxt_tx_st = tx_st_ff;
		unique case (tx_st_ff)
			dcm_pkg::TX_IDLE: begin
				if (req_pend_ff & fifo_out_valid) begin
					nxt_tx_st = (history & ~SERVER_POLL_MODE) ?
					            dcm_pkg::TX_SEND : dcm_pkg::TX_DROP;
				end
			end
			dcm_pkg::TX_DROP: begin
				if (one_left) begin
					nxt_tx_st = dcm_pkg::TX_SEND;
				end
			end
			dcm_pkg::TX_SEND: begin
				if (~fifo_out_valid | (pop_send & send_last)) begin
					nxt_tx_st = dcm_pkg::TX_IDLE;
				end
			end
			default: begin
				nxt_tx_st = dcm_pkg::TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			tx_st_ff    <= dcm_pkg::TX_IDLE;
			sent_ff     <= '0;
			out_vld_ff  <= 1'b0;
			out_last_ff <= 1'b0;
			out_data_ff <= '0;
		end else begin
			tx_st_ff    <= nxt_tx_st;
			sent_ff     <= (tx_st_ff != dcm_pkg::TX_SEND) ? '0 : sent_ff + 8'(pop_send);
			out_vld_ff  <= (pop_send | live_send) | (out_vld_ff & ~MSG_READY);
			out_last_ff <= pop_send ? send_last : (live_send | (out_last_ff & ~MSG_READY));
			out_data_ff <= pop_send ? fifo_out_data :
			               live_send ? live_word : out_data_ff;
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Uplink back-pressure only stalls the message path, never the inputs
	logic [NI-1:0] cos_pls_ff;
	logic [NI-1:0] dur_pls_ff;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cos_pls_ff <= '0;
			dur_pls_ff <= '0;
		end else begin
			cos_pls_ff <= cos_hit;
			dur_pls_ff <= dur_hit;
		end
	end

	assign INPUT_STATE     = stable;
	assign COS_ALARM_FLAG  = cos_flag;
	assign DUR_ALARM_FLAG  = dur_flag;
	assign COS_ALARM_PULSE = cos_pls_ff;
	assign DUR_ALARM_PULSE = dur_pls_ff;
	assign MSG_VALID       = out_vld_ff;
	assign MSG_DATA        = out_data_ff;
	assign MSG_LAST        = out_last_ff;
endmodule : dcm_monitor

// ---- testbench/dcm_props.sv ----
`timescale 1ns/1ps
module dcm_props #(
	parameter int P_CYC_PER_MS = dcm_pkg::CYC_PER_MS
) (
	// Clock and reset
	input wire logic                        CLK_SYS,
	input wire logic                        RST,
	// Inputs watched
	input wire logic                        CONTACT_INPUT_FIRST,
	input wire logic                        SERVER_POLL_MODE,
	input wire logic [dcm_pkg::NUM_IN-1:0]  INPUT_ENABLE,
	input wire logic [dcm_pkg::NUM_IN-1:0]  EVT_CNT_CLR,
	input wire logic                        SERVER_READ_REQ,
	input wire logic                        MSG_READY,
	// Outputs watched
	input wire logic [dcm_pkg::NUM_IN-1:0]  INPUT_STATE,
	input wire logic [dcm_pkg::NUM_IN-1:0]  COS_ALARM_FLAG,
	input wire logic [dcm_pkg::NUM_IN-1:0]  DUR_ALARM_FLAG,
	input wire logic [dcm_pkg::NUM_IN-1:0]  COS_ALARM_PULSE,
	input wire logic [dcm_pkg::NUM_IN-1:0]  DUR_ALARM_PULSE,
	input wire logic                        MSG_VALID,
	input wire logic [dcm_pkg::WORD_W-1:0]  MSG_DATA,
	input wire logic                        MSG_LAST
);
	// ----------------------------------------
	// Pin quiet time
	// ----------------------------------------
	localparam int SETTLE = (dcm_pkg::DEB_MIN_MS - 1) * P_CYC_PER_MS;
	logic       pin_q_ff;
	logic [7:0] stab_ff;
	logic [3:0] age_ff;
	logic [7:0] nxt_stab;
	logic [3:0] nxt_age;
	// Saturating, so a long quiet spell never wraps under the bound
	assign nxt_stab = (pin_q_ff != CONTACT_INPUT_FIRST) ? 8'h00 :
	                  stab_ff + {7'h00, stab_ff != 8'hFF};
	assign nxt_age  = age_ff + {3'h0, age_ff != 4'hF};
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			pin_q_ff <= 1'b0;
			stab_ff  <= 8'h00;
			age_ff   <= 4'h0;
		end else begin
			pin_q_ff <= CONTACT_INPUT_FIRST;
			stab_ff  <= nxt_stab;
			age_ff   <= nxt_age;
		end
	end
	// ----------------------------------------
	// Words of the open message
	// ----------------------------------------
	logic [7:0] wc_ff;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			wc_ff <= 8'h00;
		end else if (MSG_VALID && MSG_READY) begin
			wc_ff <= MSG_LAST ? 8'h00 : wc_ff + 8'h01;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking dcm_cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_state_settled: assert property ($changed(INPUT_STATE[0]) && INPUT_ENABLE[0]
		&& age_ff == 4'hF |-> stab_ff >= SETTLE)
		else $error("state changed on a pin that was not quiet");
	a_cos_pulse_follows: assert property ($rose(COS_ALARM_FLAG[0]) |-> COS_ALARM_PULSE[0])
		else $error("count alarm pulse missing");
	a_cos_pulse_single: assert property (COS_ALARM_PULSE[0] |=> !COS_ALARM_PULSE[0])
		else $error("count alarm pulse too long");
	a_dur_pulse_once: assert property ($rose(DUR_ALARM_FLAG[0])
		|-> DUR_ALARM_PULSE[0] ##1 !DUR_ALARM_PULSE[0])
		else $error("duration alarm pulse wrong");
	a_flag_clear: assert property (EVT_CNT_CLR[0]
		|=> !COS_ALARM_FLAG[0] || COS_ALARM_PULSE[0])
		else $error("count alarm flag survived clear");
	a_msg_hold: assert property (MSG_VALID && !MSG_READY
		|=> MSG_VALID && $stable(MSG_DATA) && $stable(MSG_LAST))
		else $error("message word dropped before accept");
	a_last_in_msg: assert property (MSG_LAST |-> MSG_VALID)
		else $error("last marker without valid");
	a_hist_cap: assert property (MSG_VALID |-> wc_ff < 8'(dcm_pkg::MAX_HIST))
		else $error("message longer than the history cap");
	a_poll_reply_only: assert property ($rose(MSG_VALID) && SERVER_POLL_MODE
		|-> $past(SERVER_READ_REQ, 2) || $past(SERVER_READ_REQ, 3) || $past(SERVER_READ_REQ, 4))
		else $error("poll mode message without request");
	a_off_slice_zero: assert property (MSG_VALID && !INPUT_ENABLE[1]
		|-> MSG_DATA[dcm_pkg::WORD_W-1:dcm_pkg::SLICE_W] == '0)
		else $error("disabled input reported");
endmodule : dcm_props

bind dcm_monitor dcm_props #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_props (.CLK_SYS, .RST,
	.CONTACT_INPUT_FIRST, .SERVER_POLL_MODE, .INPUT_ENABLE, .EVT_CNT_CLR, .SERVER_READ_REQ,
	.MSG_READY, .INPUT_STATE, .COS_ALARM_FLAG, .DUR_ALARM_FLAG, .COS_ALARM_PULSE,
	.DUR_ALARM_PULSE, .MSG_VALID, .MSG_DATA, .MSG_LAST);

// ---- testbench/dcm_contact_model.sv ----
`timescale 1ns/1ps
module dcm_contact_model (
	// Contact levels, open contact reads high
	output logic pin_first,
	output logic pin_second
);
	initial begin
		pin_first  = 1'b1;
		pin_second = 1'b1;
	end
	// Chatter before settling, as worn contacts do
	task automatic move(input int idx, input logic lvl, input int bounces);
		for (int i = 2 * bounces; i >= 0; i--) begin
			if (idx == 0) pin_first = lvl ^ i[0];
			else pin_second = lvl ^ i[0];
			#7;
		end
	endtask : move
endmodule : dcm_contact_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef struct {logic [1:0] det; logic [31:0] ev; logic flag;} dcm_row_s;
	logic             clk_sys = 1'b0, rst = 1'b1, poll = 1'b1, req = 1'b0, rdy = 1'b0;
	logic [1:0]       en = 2'h3, tcen = 2'h0, eclr = 2'h0, tclr = 2'h0;
	logic [1:0][1:0]  det = {2'h2, 2'h2};
	logic [1:0][19:0] deb = {20'h0_000A, 20'h0_000A};
	logic [1:0][30:0] cos = {31'h0000_0001, 31'h0000_0002}, dur = '0;
	logic [19:0]      smp = 20'h9_3A80, txi = 20'h0_0000;
	logic [1:0]       st, cf, df, cp, dp;
	logic             mv, ml, pin_a, pin_b;
	logic [131:0]     d;
	int               err_count = 0, samples_checked = 0, n, nv;
	dcm_row_s         rows [4] = '{'{2'h0, 32'h0000_0001, 1'b0}, '{2'h1, 32'h0000_0001, 1'b0},
		'{2'h2, 32'h0000_0002, 1'b1}, '{2'h3, 32'h0000_0000, 1'b0}};
	always #5 clk_sys = ~clk_sys;
	dcm_contact_model u_sw (.pin_first(pin_a), .pin_second(pin_b));
	dcm_monitor #(.P_CYC_PER_MS(4), .P_MS_PER_S(4), .P_S_PER_MIN(2)) i_dut (.CLK_SYS(clk_sys),
		.RST(rst), .CONTACT_INPUT_FIRST(pin_a), .CONTACT_INPUT_SECOND(pin_b),
		.SERVER_POLL_MODE(poll), .INPUT_ENABLE(en), .SAMPLE_PERIOD_S(smp), .TX_INTERVAL_S(txi),
		.DETECT_TYPE(det), .DEBOUNCE_MS(deb), .TIME_CNT_EN(tcen), .COS_THRESHOLD(cos),
		.DUR_THRESHOLD_S(dur), .EVT_CNT_CLR(eclr), .TIME_CNT_CLR(tclr), .SERVER_READ_REQ(req),
		.INPUT_STATE(st), .COS_ALARM_FLAG(cf), .DUR_ALARM_FLAG(df), .COS_ALARM_PULSE(cp),
		.DUR_ALARM_PULSE(dp), .MSG_VALID(mv), .MSG_READY(rdy), .MSG_DATA(d), .MSG_LAST(ml));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h", $time, m, got);
		end
	endtask : chk
	task automatic stop_test;
		$display("TB: checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	// Uplink stalls two cycles on every word
	task automatic get_word(output logic [131:0] w, output logic l);
		int k;
		k = 0;
		while (mv !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
		chk({31'h0000_0000, mv}, 32'h0000_0001, "no message word");
		tick(2);
		rdy = 1'b1;
		w = d;
		l = ml;
		tick(1);
		rdy = 1'b0;
	endtask : get_word
	task automatic get_msg(output int c);
		logic [131:0] w;
		logic l;
		c = 0;
		do begin
			get_word(w, l);
			c++;
		end while (l !== 1'b1 && c < 60);
	endtask : get_msg
	task automatic poll_read(output logic [131:0] w);
		logic l;
		req = 1'b1;
		tick(1);
		req = 1'b0;
		get_word(w, l);
		chk({31'h0000_0000, l}, 32'h0000_0001, "poll reply not single word");
	endtask : poll_read
	task automatic pulse_clr;
		eclr = 2'h3;
		tclr = 2'h3;
		tick(1);
		eclr = 2'h0;
		tclr = 2'h0;
		tick(2);
	endtask : pulse_clr
	task automatic watch(input int c);
		nv = 0;
		repeat (c) begin
			tick(1);
			nv += (mv === 1'b1);
		end
	endtask : watch
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		logic [131:0] w;
		repeat (3) @(posedge clk_sys);
		#1 rst = 1'b0;
		tick(10);
		foreach (rows[i]) begin
			det[0] = rows[i].det;
			pulse_clr();
			u_sw.move(0, 1'b0, 3);
			tick(80);
			u_sw.move(0, 1'b1, 3);
			tick(80);
			poll_read(w);
			chk(w[63:32], rows[i].ev, "event count");
			chk({30'h0000_0000, w[65:64]}, 32'h0000_0003, "slice state");
			chk({31'h0000_0000, cf[0]}, {31'h0000_0000, rows[i].flag}, "count alarm");
			chk({31'h0000_0000, st[0]}, 32'h0000_0001, "input state");
		end
		$display("detection rows done");
		det[0] = 2'h2;
		pulse_clr();
		u_sw.move(0, 1'b0, 0);
		tick(20);
		u_sw.move(0, 1'b1, 0);
		tick(80);
		poll_read(w);
		chk(w[63:32], 32'h0000_0000, "short pulse counted");
		en = 2'h1;
		u_sw.move(1, 1'b0, 2);
		tick(80);
		poll_read(w);
		chk({31'h0000_0000, w[131:66] == '0}, 32'h0000_0001, "disabled input sent");
		u_sw.move(1, 1'b1, 0);
		tick(4);
		en = 2'h3;
		$display("bounce and disable done");
		det[0] = dcm_pkg::DET_LOW;
		tcen[0] = 1'b1;
		dur[0] = 31'h0000_0002;
		pulse_clr();
		u_sw.move(0, 1'b0, 2);
		tick(100);
		poll_read(w);
		chk({31'h0000_0000, w[31:0] >= 32'h0000_0003 && w[31:0] <= 32'h0000_0007},
			32'h0000_0001, "time count");
		chk({31'h0000_0000, df[0]}, 32'h0000_0001, "duration alarm");
		u_sw.move(0, 1'b1, 0);
		watch(100);
		chk(nv, 0, "unrequested poll message");
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(10);
		poll_read(w);
		chk(w[63:32], 32'h0000_0000, "counter kept over reset");
		$display("duration and reset done");
		poll = 1'b0;
		smp = 20'h0_003C;
		txi = 20'h0_001E;
		watch(200);
		chk(nv, 0, "sub-minute interval sent");
		txi = 20'h0_0078;
		get_msg(n);
		get_msg(n);
		chk({31'h0000_0000, n >= 2 && n <= 48}, 32'h0000_0001, "history size");
		txi = 20'h0_003C;
		get_msg(n);
		get_msg(n);
		chk(n, 1, "equal intervals sent history");
		$display("push mode done");
		stop_test();
	end
	initial begin
		#1_000_000;
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		stop_test();
	end
endmodule : tb_top
